/* File: verilog/serial_ctrl.sv */
/*
  Control, reset, divisor and interrupt logic of an asynchronous serial
  controller, reached over a classic Wishbone slave port.
  Assumes the shift datapath and FIFOs sit outside, report levels and
  one-cycle event pulses on core_clk, and obey the enables given here.
*/
module serial_ctrl #(
  parameter int TX_DEPTH = 4,
  parameter int RX_DEPTH = 6
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic request_n,
  output logic clear_n,
  output logic dsr,
  input wire logic [2:0] tx_count,
  input wire logic tx_busy,
  input wire logic tx_bit_tick,
  input wire logic [2:0] rx_count,
  input wire logic rx_bit_tick,
  input wire logic serial_in,
  input wire logic rx_start_fall,
  input wire logic rx_start_end,
  input wire logic parity_err,
  input wire logic framing_err,
  input wire logic overrun,
  output logic tx_line_break,
  output logic tx_allowed,
  output logic rx_allowed,
  output logic two_stop,
  output logic [10:0] baud_divisor,
  output logic speed_match,
  output logic core_reset,
  output logic tx_clear,
  output logic rx_clear,
  output logic tx_irq_n,
  output logic rx_irq_n
);
  // ==========================================================
  // Registers
  logic [7:0] line_ctrl_reg;
  logic [7:0] mode_ctrl_reg;
  logic [7:0] div_low_reg;
  logic [7:0] reset_ctrl_reg;
  logic [7:0] queue_cfg_reg;
  logic ack_reg;
  logic [7:0] rd_reg;
  logic [2:0] srst_cnt_reg;
  logic [2:0] txc_cnt_reg;
  logic [2:0] rxc_cnt_reg;
  serial_ctrl_pkg::brk_state_type brk_reg;
  logic [3:0] brk_bits_reg;
  logic [3:0] rx_low_reg;
  logic break_seen_reg;
  logic err_seen_reg;
  logic spm_irq_reg;
  logic spm_armed_reg;
  logic req_seen_reg;
  logic request_d_reg;
  logic tx_flag_n_reg;
  logic rx_flag_n_reg;
  logic clear_n_reg;
  logic tx_irq_reg;
  logic rx_irq_reg;

  logic int_rst;
  logic wr;
  logic wr_rc;
  logic rd;
  logic [5:0] idx;
  logic [7:0] wdat;
  serial_ctrl_pkg::ctrl_mode_type mode;
  logic tx_cond;
  logic rx_level_hit;
  logic rx_cond;
  logic rx_break_hit;
  logic [7:0] status;

  // ==========================================================
  // Bus slave: ack one cycle after the request, writes at the ack edge
  assign idx = wb_adr_i[7:2];
  assign wdat = wb_dat_i[7:0];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && ack_reg;
  assign wr_rc = wr && (idx == serial_ctrl_pkg::RESET_CTRL_IDX);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = {24'h000000, rd_reg};

  // Ack toggles low the cycle after it is given
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // Read mux, unmapped indices read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_reg <= 8'h00;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      case (idx)
        serial_ctrl_pkg::LINE_CTRL_IDX: rd_reg <= line_ctrl_reg;
        serial_ctrl_pkg::MODE_CTRL_IDX: rd_reg <= mode_ctrl_reg;
        serial_ctrl_pkg::DIV_LOW_IDX: rd_reg <= div_low_reg;
        serial_ctrl_pkg::RESET_CTRL_IDX: rd_reg <= reset_ctrl_reg;
        serial_ctrl_pkg::QUEUE_CFG_IDX: rd_reg <= queue_cfg_reg;
        serial_ctrl_pkg::STATUS_IDX: rd_reg <= status;
        default: rd_reg <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Software and side resets
  // Bus logic stays on the pin reset so a soft reset never breaks a cycle
  assign int_rst = rst || (srst_cnt_reg != 3'h0);
  assign core_reset = int_rst;
  assign tx_clear = int_rst || (txc_cnt_reg != 3'h0);
  assign rx_clear = int_rst || (rxc_cnt_reg != 3'h0);

  // Self-clearing counters, each active four cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      srst_cnt_reg <= 3'h0;
    end else if (wr_rc && wdat[serial_ctrl_pkg::SRST_BIT]) begin
      srst_cnt_reg <= serial_ctrl_pkg::SELF_CLEAR_CYCLES;
    end else if (srst_cnt_reg != 3'h0) begin
      srst_cnt_reg <= srst_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      txc_cnt_reg <= 3'h0;
    end else if (wr_rc && wdat[serial_ctrl_pkg::TXCLR_BIT]) begin
      txc_cnt_reg <= serial_ctrl_pkg::SELF_CLEAR_CYCLES;
    end else if (txc_cnt_reg != 3'h0) begin
      txc_cnt_reg <= txc_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      rxc_cnt_reg <= 3'h0;
    end else if (wr_rc && wdat[serial_ctrl_pkg::RXCLR_BIT]) begin
      rxc_cnt_reg <= serial_ctrl_pkg::SELF_CLEAR_CYCLES;
    end else if (rxc_cnt_reg != 3'h0) begin
      rxc_cnt_reg <= rxc_cnt_reg - 3'h1;
    end
  end

  // ==========================================================
  // Control registers, cleared by either reset, never by side clears
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      line_ctrl_reg <= serial_ctrl_pkg::LINE_CTRL_RST;
      mode_ctrl_reg <= serial_ctrl_pkg::MODE_CTRL_RST;
      div_low_reg <= serial_ctrl_pkg::DIV_LOW_RST;
      queue_cfg_reg <= serial_ctrl_pkg::QUEUE_CFG_RST;
    end else if (wr) begin
      if (idx == serial_ctrl_pkg::LINE_CTRL_IDX) line_ctrl_reg <= wdat;
      if (idx == serial_ctrl_pkg::MODE_CTRL_IDX) mode_ctrl_reg <= wdat;
      if (idx == serial_ctrl_pkg::DIV_LOW_IDX) div_low_reg <= wdat;
      if (idx == serial_ctrl_pkg::QUEUE_CFG_IDX) queue_cfg_reg <= wdat;
    end
  end

  // Reset-control: strobe bits always read zero, speed match clears on start
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      reset_ctrl_reg <= serial_ctrl_pkg::RESET_CTRL_RST;
    end else begin
      if (wr && idx == serial_ctrl_pkg::RESET_CTRL_IDX) begin
        reset_ctrl_reg <= {wdat[7], 3'h0, wdat[3:0]};
      end
      if (rx_start_fall) begin
        reset_ctrl_reg[serial_ctrl_pkg::SPM_BIT] <= 1'b0;
      end
    end
  end

  assign dsr = reset_ctrl_reg[serial_ctrl_pkg::DSR_BIT];
  assign baud_divisor = {reset_ctrl_reg[2:0], div_low_reg};
  assign speed_match = reset_ctrl_reg[serial_ctrl_pkg::SPM_BIT];
  assign two_stop = mode_ctrl_reg[serial_ctrl_pkg::STOP_BIT];
  assign mode = serial_ctrl_pkg::ctrl_mode_type'(mode_ctrl_reg[7:6]);

  // ==========================================================
  // Flow control per mode
  // Transmitter pauses on request only where the mode waits for it
  always_comb begin
    tx_allowed = line_ctrl_reg[serial_ctrl_pkg::TRANSMITTER_ENABLE_BIT] && !speed_match;
    rx_allowed = line_ctrl_reg[serial_ctrl_pkg::RECEIVER_ENABLE_BIT];
    if (mode == serial_ctrl_pkg::MODE_EIA || mode == serial_ctrl_pkg::MODE_DTE) begin
      tx_allowed = tx_allowed && !request_n;
    end
  end

  // Clear output, registered to keep the pin glitch free
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      clear_n_reg <= 1'b1;
    end else begin
      case (mode)
        serial_ctrl_pkg::MODE_DTE:
          clear_n_reg <= !(tx_count != 3'h0 && line_ctrl_reg[serial_ctrl_pkg::TRANSMITTER_ENABLE_BIT]);
        serial_ctrl_pkg::MODE_DCE:
          clear_n_reg <= !(!request_n && line_ctrl_reg[serial_ctrl_pkg::RECEIVER_ENABLE_BIT]
                           && rx_count < 3'(RX_DEPTH));
        default: clear_n_reg <= !line_ctrl_reg[serial_ctrl_pkg::GP_OUT_BIT];
      endcase
    end
  end
  assign clear_n = clear_n_reg;

  // ==========================================================
  // Break generation in whole groups of ten bit times
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      brk_reg <= serial_ctrl_pkg::BRK_IDLE;
      brk_bits_reg <= 4'h0;
    end else begin
      case (brk_reg)
        serial_ctrl_pkg::BRK_IDLE: begin
          brk_bits_reg <= 4'h0;
          if (mode_ctrl_reg[serial_ctrl_pkg::BRK_BIT] && tx_allowed) begin
            brk_reg <= tx_busy ? serial_ctrl_pkg::BRK_WAIT : serial_ctrl_pkg::BRK_SEND;
          end
        end
        serial_ctrl_pkg::BRK_WAIT: begin
          if (!mode_ctrl_reg[serial_ctrl_pkg::BRK_BIT]) begin
            brk_reg <= serial_ctrl_pkg::BRK_IDLE;
          end else if (!tx_busy) begin
            brk_reg <= serial_ctrl_pkg::BRK_SEND;
          end
        end
        serial_ctrl_pkg::BRK_SEND: begin
          if (tx_bit_tick) begin
            if (brk_bits_reg == serial_ctrl_pkg::BREAK_BITS - 4'h1) begin
              brk_bits_reg <= 4'h0;
              if (!mode_ctrl_reg[serial_ctrl_pkg::BRK_BIT]) begin
                brk_reg <= serial_ctrl_pkg::BRK_IDLE;
              end
            end else begin
              brk_bits_reg <= brk_bits_reg + 4'h1;
            end
          end
        end
        default: brk_reg <= serial_ctrl_pkg::BRK_IDLE;
      endcase
    end
  end
  assign tx_line_break = (brk_reg == serial_ctrl_pkg::BRK_SEND);

  // ==========================================================
  // Receive break detection and sticky event latches
  always_ff @(posedge core_clk) begin
    if (rx_clear) begin
      rx_low_reg <= 4'h0;
    end else if (rx_bit_tick) begin
      if (!serial_in && rx_allowed) begin
        if (rx_low_reg != serial_ctrl_pkg::RX_BREAK_BITS) rx_low_reg <= rx_low_reg + 4'h1;
      end else begin
        rx_low_reg <= 4'h0;
      end
    end
  end
  assign rx_break_hit = rx_bit_tick && !serial_in && rx_allowed
                        && rx_low_reg == serial_ctrl_pkg::RX_BREAK_BITS - 4'h1;

  // Status read clears latches, but a new event in that cycle wins
  always_ff @(posedge core_clk) begin
    if (rx_clear) begin
      break_seen_reg <= 1'b0;
      err_seen_reg <= 1'b0;
    end else begin
      if (rx_break_hit) begin
        break_seen_reg <= 1'b1;
      end else if (rd && idx == serial_ctrl_pkg::STATUS_IDX) begin
        break_seen_reg <= 1'b0;
      end
      if (parity_err || framing_err || overrun) begin
        err_seen_reg <= 1'b1;
      end else if (rd && idx == serial_ctrl_pkg::STATUS_IDX) begin
        err_seen_reg <= 1'b0;
      end
    end
  end

  // Start fall clears the bit before the start bit ends, so remember it
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      spm_armed_reg <= 1'b0;
    end else if (rx_start_fall && speed_match) begin
      spm_armed_reg <= 1'b1;
    end else if (rx_start_end) begin
      spm_armed_reg <= 1'b0;
    end
  end

  // Speed-match interrupt holds until software writes the bit to zero
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      spm_irq_reg <= 1'b0;
    end else if (rx_start_end && (speed_match || spm_armed_reg)) begin
      spm_irq_reg <= 1'b1;
    end else if (wr_rc && !wdat[serial_ctrl_pkg::SPM_BIT]) begin
      spm_irq_reg <= 1'b0;
    end
  end

  // Request falling edge in DCE mode, latched until status read
  always_ff @(posedge core_clk) begin
    if (tx_clear) begin
      request_d_reg <= 1'b1;
      req_seen_reg <= 1'b0;
    end else begin
      request_d_reg <= request_n;
      if (request_d_reg && !request_n && mode == serial_ctrl_pkg::MODE_DCE) begin
        req_seen_reg <= 1'b1;
      end else if (rd && idx == serial_ctrl_pkg::STATUS_IDX) begin
        req_seen_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt conditions
  always_comb begin
    case (queue_cfg_reg[7:6])
      2'h0: tx_cond = (tx_count == 3'h0);
      2'h1: tx_cond = (3'(TX_DEPTH) - tx_count >= 3'h3);
      2'h2: tx_cond = (3'(TX_DEPTH) - tx_count >= 3'h2);
      default: tx_cond = (3'(TX_DEPTH) - tx_count >= 3'h1);
    endcase
    tx_cond = tx_cond || (queue_cfg_reg[serial_ctrl_pkg::REQIE_BIT] && req_seen_reg);
  end

  // Level code zero means the speed-match event; code seven left to the host
  assign rx_level_hit = (queue_cfg_reg[5:3] == 3'h0) ? spm_irq_reg
                        : (rx_count >= queue_cfg_reg[5:3]);
  assign rx_cond = rx_level_hit
                   || (queue_cfg_reg[serial_ctrl_pkg::ERRIE_BIT] && err_seen_reg)
                   || (queue_cfg_reg[serial_ctrl_pkg::BRKIE_BIT] && break_seen_reg);

  // Flags ignore the master enable so software can poll
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      tx_flag_n_reg <= 1'b1;
      rx_flag_n_reg <= 1'b1;
      tx_irq_reg <= 1'b1;
      rx_irq_reg <= 1'b1;
    end else begin
      tx_flag_n_reg <= !(mode_ctrl_reg[serial_ctrl_pkg::TXIE_BIT] && tx_cond);
      rx_flag_n_reg <= !(mode_ctrl_reg[serial_ctrl_pkg::RXIE_BIT] && rx_cond);
      tx_irq_reg <= !(mode_ctrl_reg[serial_ctrl_pkg::MIRQ_BIT]
                      && mode_ctrl_reg[serial_ctrl_pkg::TXIE_BIT] && tx_cond);
      rx_irq_reg <= !(mode_ctrl_reg[serial_ctrl_pkg::MIRQ_BIT]
                      && mode_ctrl_reg[serial_ctrl_pkg::RXIE_BIT] && rx_cond);
    end
  end
  assign tx_irq_n = tx_irq_reg;
  assign rx_irq_n = rx_irq_reg;

  assign status = {break_seen_reg, !request_n, rx_flag_n_reg, tx_flag_n_reg,
                   err_seen_reg, spm_irq_reg, tx_line_break, req_seen_reg};

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_master_gate;
    !mode_ctrl_reg[serial_ctrl_pkg::MIRQ_BIT] && !int_rst |=> tx_irq_n && rx_irq_n;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("irq while master off");

  property p_brk_waits;
    brk_reg == serial_ctrl_pkg::BRK_WAIT && tx_busy && !int_rst
      |=> brk_reg != serial_ctrl_pkg::BRK_SEND;
  endproperty
  a_brk_waits: assert property (p_brk_waits) else $error("break cut a character");

  property p_brk_tens;
    brk_reg == serial_ctrl_pkg::BRK_SEND
      ##1 brk_reg == serial_ctrl_pkg::BRK_IDLE && !$past(int_rst)
      |-> $past(brk_bits_reg) == 4'h9 && $past(tx_bit_tick);
  endproperty
  a_brk_tens: assert property (p_brk_tens) else $error("break not ten bits");

  property p_srst_len;
    $rose(srst_cnt_reg != 3'h0) |-> core_reset [*4] ##1 !core_reset;
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");

  property p_dte_clear;
    mode == serial_ctrl_pkg::MODE_DTE && !int_rst && tx_count != 3'h0
      && line_ctrl_reg[serial_ctrl_pkg::TRANSMITTER_ENABLE_BIT] |=> !clear_n;
  endproperty
  a_dte_clear: assert property (p_dte_clear) else $error("dte clear not low");

  property p_rx_break;
    rx_break_hit && !rx_clear |=> break_seen_reg;
  endproperty
  a_rx_break: assert property (p_rx_break) else $error("break not caught");

  property p_spm_fall;
    rx_start_fall && !int_rst && !(wr && idx == serial_ctrl_pkg::RESET_CTRL_IDX)
      |=> !speed_match;
  endproperty
  a_spm_fall: assert property (p_spm_fall) else $error("speed match stayed");

  property p_spm_irq;
    spm_armed_reg && rx_start_end && !int_rst |=> spm_irq_reg;
  endproperty
  a_spm_irq: assert property (p_spm_irq) else $error("speed match irq lost");

  property p_tx_empty;
    queue_cfg_reg[7:6] == 2'h0 && tx_count == 3'h0 && !int_rst
      && mode_ctrl_reg[serial_ctrl_pkg::TXIE_BIT] |=> !tx_flag_n_reg;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag missing");

  property p_soft_keeps_bus;
    wb_cyc_i && wb_stb_i && !ack_reg |=> ack_reg;
  endproperty
  a_soft_keeps_bus: assert property (p_soft_keeps_bus) else $error("no ack");

  c_break: cover property (brk_reg == serial_ctrl_pkg::BRK_WAIT ##[1:50] tx_line_break);
  c_soft: cover property ($rose(srst_cnt_reg != 3'h0));
  c_rx_irq: cover property ($fell(rx_irq_n));
  c_spm: cover property ($rose(spm_irq_reg));
endmodule

/* File: verilog/serial_ctrl_pkg.sv */
/*
  Constants for the serial controller's configuration block: register
  indices, field positions, reset values, control modes and break states.
  Assumes a Wishbone slave with 32-bit data, one register per aligned word.
*/
package serial_ctrl_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] LINE_CTRL_IDX = 6'h01;
  localparam logic [5:0] MODE_CTRL_IDX = 6'h02;
  localparam logic [5:0] DIV_LOW_IDX = 6'h03;
  localparam logic [5:0] RESET_CTRL_IDX = 6'h04;
  localparam logic [5:0] QUEUE_CFG_IDX = 6'h05;
  localparam logic [5:0] STATUS_IDX = 6'h06;
  // ==========================================================
  // Field positions
  localparam int RECEIVER_ENABLE_BIT = 7;
  localparam int TRANSMITTER_ENABLE_BIT = 6;
  localparam int GP_OUT_BIT = 0;
  localparam int ROLE_BIT = 7;
  localparam int HAND_BIT = 6;
  localparam int BRK_BIT = 5;
  localparam int MIRQ_BIT = 4;
  localparam int TXIE_BIT = 3;
  localparam int RXIE_BIT = 2;
  localparam int STOP_BIT = 1;
  localparam int DSR_BIT = 7;
  localparam int SRST_BIT = 6;
  localparam int TXCLR_BIT = 5;
  localparam int RXCLR_BIT = 4;
  localparam int SPM_BIT = 3;
  localparam int ERRIE_BIT = 2;
  localparam int REQIE_BIT = 1;
  localparam int BRKIE_BIT = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] LINE_CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST = 8'h01;
  localparam logic [7:0] DIV_LOW_RST = 8'h00;
  localparam logic [7:0] RESET_CTRL_RST = 8'h80;
  localparam logic [7:0] QUEUE_CFG_RST = 8'h08;
  // ==========================================================
  // Counts
  localparam logic [2:0] SELF_CLEAR_CYCLES = 3'h4;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  localparam logic [3:0] RX_BREAK_BITS = 4'hA;
  // ==========================================================
  // Control modes: role bit over handshake bit
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'h0,
    MODE_DCE = 2'h1,
    MODE_EIA = 2'h2,
    MODE_DTE = 2'h3
  } ctrl_mode_type;
  typedef enum logic [2:0] {
    BRK_IDLE = 3'h1,
    BRK_WAIT = 3'h2,
    BRK_SEND = 3'h4
  } brk_state_type;
endpackage

/* File: dv/far_side_model.sv */
/*
  Behavioural far side of the control block: serial datapath and remote
  terminal. Bit ticks run every four cycles; levels and pulses follow the
  bench's commands. Assumes one core_clk domain and synchronous rst.
*/
module far_side_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_low,
  input wire logic send_break,
  input wire logic start_kick,
  input wire logic [2:0] err_kick,
  input wire logic [2:0] tx_fill,
  input wire logic [2:0] rx_fill,
  output logic request_n,
  output logic [2:0] tx_count,
  output logic tx_busy,
  output logic tx_bit_tick,
  output logic [2:0] rx_count,
  output logic rx_bit_tick,
  output logic serial_in,
  output logic rx_start_fall,
  output logic rx_start_end,
  output logic parity_err,
  output logic framing_err,
  output logic overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_reg;
  // ==========================================================
  // Bit timing: free running, slow enough to see ten-bit breaks
  always_ff @(posedge core_clk) begin
    tick_reg <= rst ? 2'h0 : tick_reg + 2'h1;
    tx_bit_tick <= (tick_reg == 2'h3);
    rx_bit_tick <= (tick_reg == 2'h3);
  end
  // Line level: a held break gives ten or more low samples
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_in <= 1'b1;
    end else if (tick_reg == 2'h3) begin
      serial_in <= ~send_break;
    end
  end
  // Levels and one-cycle event pulses
  always_ff @(posedge core_clk) begin
    request_n <= ~req_low;
    tx_count <= tx_fill;
    tx_busy <= (tx_fill != 3'h0);
    rx_count <= rx_fill;
    rx_start_fall <= start_kick;
    rx_start_end <= rx_start_fall;
    {overrun, framing_err, parity_err} <= err_kick;
  end
endmodule

/* File: dv/serial_ctrl_tb.sv */
/*
  Self-checking bench for serial_ctrl: classic Wishbone master tasks, a
  read scoreboard queue and pin checks. Assumes far_side_model drives the
  datapath inputs and the register map of serial_ctrl_pkg.
*/
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module serial_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, cyc, stb, we, req_low, send_break, start_kick;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat;
  logic [2:0] err_kick, tx_fill, rx_fill;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, request_n, clear_n, dsr, tx_busy, tx_bit_tick, rx_bit_tick;
  logic serial_in, rx_start_fall, rx_start_end, parity_err, framing_err, overrun;
  logic tx_line_break, tx_allowed, rx_allowed, two_stop, speed_match;
  logic core_reset, tx_clear, rx_clear, tx_irq_n, rx_irq_n;
  logic [2:0] tx_count, rx_count;
  logic [10:0] baud_divisor;
  logic [31:0] exp_q[$];
  logic [7:0] d;
  logic [3:0] mode_exp;
  int n_mismatch, comparisons, seed, k, n;
  serial_ctrl u_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .request_n(request_n), .clear_n(clear_n), .dsr(dsr),
    .tx_count(tx_count), .tx_busy(tx_busy), .tx_bit_tick(tx_bit_tick),
    .rx_count(rx_count), .rx_bit_tick(rx_bit_tick), .serial_in(serial_in),
    .rx_start_fall(rx_start_fall), .rx_start_end(rx_start_end), .parity_err(parity_err),
    .framing_err(framing_err), .overrun(overrun), .tx_line_break(tx_line_break),
    .tx_allowed(tx_allowed), .rx_allowed(rx_allowed), .two_stop(two_stop),
    .baud_divisor(baud_divisor), .speed_match(speed_match), .core_reset(core_reset),
    .tx_clear(tx_clear), .rx_clear(rx_clear), .tx_irq_n(tx_irq_n), .rx_irq_n(rx_irq_n));
  far_side_model u_far (.core_clk(core_clk), .rst(rst), .req_low(req_low),
    .send_break(send_break), .start_kick(start_kick), .err_kick(err_kick),
    .tx_fill(tx_fill), .rx_fill(rx_fill), .request_n(request_n), .tx_count(tx_count),
    .tx_busy(tx_busy), .tx_bit_tick(tx_bit_tick), .rx_count(rx_count),
    .rx_bit_tick(rx_bit_tick), .serial_in(serial_in), .rx_start_fall(rx_start_fall),
    .rx_start_end(rx_start_end), .parity_err(parity_err), .framing_err(framing_err),
    .overrun(overrun));
  // ==========================================================
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
  // Scoreboard: oldest note against each read answer
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      `CHK("read data", exp_q.pop_front(), wb_dat_o)
    end
  end
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Single classic cycle; waits on ack with a bound, never on a count
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] v);
    int c;
    @(posedge core_clk);
    {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'h1, idx, 2'h0, 24'h0, v};
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (wb_ack_o !== 1'b1 && c < 50);
    if (c >= 50) begin
      n_mismatch++;
      test_done();
    end
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h06AB09D7;
    {rst, cyc, stb, we, adr, dat, sel} = {1'b1, 3'h0, 8'h00, 32'h0, 4'h1};
    {req_low, send_break, start_kick, err_kick, tx_fill, rx_fill} = 12'h000;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(serial_ctrl_pkg::MODE_CTRL_IDX, 8'h01);
    rd(serial_ctrl_pkg::RESET_CTRL_IDX, 8'h80);
    rd(serial_ctrl_pkg::QUEUE_CFG_IDX, 8'h08);
    rd(serial_ctrl_pkg::DIV_LOW_IDX, 8'h00);
    `CHK("dsr", 1'b1, dsr)
    // Divisor split across two registers, random value
    d = 8'($random(seed));
    n = $random(seed);
    bus(1'b1, serial_ctrl_pkg::DIV_LOW_IDX, d);
    bus(1'b1, serial_ctrl_pkg::RESET_CTRL_IDX, {5'h10, n[2:0]});
    settle();
    `CHK("divisor", {n[2:0], d}, baud_divisor)
    rd(serial_ctrl_pkg::DIV_LOW_IDX, d);
    rd(6'h3F, 8'h00);
    bus(1'b1, serial_ctrl_pkg::MODE_CTRL_IDX, 8'h03);
    settle();
    `CHK("two stop", 1'b1, two_stop)
    // Four control modes with clear bit 0, request low, tx data, rx room
    bus(1'b1, serial_ctrl_pkg::LINE_CTRL_IDX, 8'hC0);
    {req_low, tx_fill} <= {1'b1, 3'h1};
    mode_exp = 4'b0101;
    for (k = 0; k < 4; k++) begin
      bus(1'b1, serial_ctrl_pkg::MODE_CTRL_IDX, {k[1:0], 6'h01});
      settle();
      `CHK("clear_n", mode_exp[k], clear_n)
    end
    // Level interrupts, gated by the master enable; flags stay pollable
    bus(1'b1, serial_ctrl_pkg::QUEUE_CFG_IDX, 8'hC8);
    rx_fill <= 3'h1;
    bus(1'b1, serial_ctrl_pkg::MODE_CTRL_IDX, 8'h1D);
    settle();
    `CHK("rx irq on", 1'b0, rx_irq_n)
    `CHK("tx irq on", 1'b0, tx_irq_n)
    bus(1'b1, serial_ctrl_pkg::QUEUE_CFG_IDX, 8'h08);
    settle();
    `CHK("tx irq level", 1'b1, tx_irq_n)
    bus(1'b1, serial_ctrl_pkg::MODE_CTRL_IDX, 8'h05);
    settle();
    `CHK("rx irq gated", 1'b1, rx_irq_n)
    rd(serial_ctrl_pkg::STATUS_IDX, 8'h50);
    // Received break plus a parity pulse, seen through status only
    {rx_fill, send_break} <= {3'h0, 1'b1};
    bus(1'b1, serial_ctrl_pkg::QUEUE_CFG_IDX, 8'h0D);
    err_kick <= 3'h1;
    @(posedge core_clk);
    err_kick <= 3'h0;
    repeat (60) @(posedge core_clk);
    `CHK("rx irq masked", 1'b1, rx_irq_n)
    rd(serial_ctrl_pkg::STATUS_IDX, 8'hD8);
    send_break <= 1'b0;
    rd(serial_ctrl_pkg::STATUS_IDX, 8'h70);
    // Speed match: start fall clears it, latch holds until written zero
    bus(1'b1, serial_ctrl_pkg::QUEUE_CFG_IDX, 8'h00);
    bus(1'b1, serial_ctrl_pkg::MODE_CTRL_IDX, 8'h15);
    bus(1'b1, serial_ctrl_pkg::RESET_CTRL_IDX, 8'h88);
    settle();
    `CHK("speed match on", 1'b1, speed_match)
    `CHK("spm irq idle", 1'b1, rx_irq_n)
    @(posedge core_clk);
    start_kick <= 1'b1;
    @(posedge core_clk);
    start_kick <= 1'b0;
    repeat (2) settle();
    `CHK("speed match off", 1'b0, speed_match)
    `CHK("spm irq on", 1'b0, rx_irq_n)
    bus(1'b1, serial_ctrl_pkg::RESET_CTRL_IDX, 8'h80);
    settle();
    `CHK("spm irq off", 1'b1, rx_irq_n)
    // Side clears last four cycles and leave control bits alone
    bus(1'b1, serial_ctrl_pkg::RESET_CTRL_IDX, 8'hB0);
    #1;
    `CHK("rx clear on", 1'b1, rx_clear)
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("tx clear held", 1'b1, tx_clear)
    @(posedge core_clk);
    #1;
    `CHK("tx clear off", 1'b0, tx_clear)
    `CHK("rx clear off", 1'b0, rx_clear)
    rd(serial_ctrl_pkg::LINE_CTRL_IDX, 8'hC0);
    // Break held back while a character is in flight, then sent
    bus(1'b1, serial_ctrl_pkg::MODE_CTRL_IDX, 8'h21);
    settle();
    `CHK("break waits", 1'b0, tx_line_break)
    @(posedge core_clk);
    tx_fill <= 3'h0;
    n = 0;
    while (tx_line_break !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("break on", 1'b1, tx_line_break)
    if (n >= 200) test_done();
    bus(1'b1, serial_ctrl_pkg::RESET_CTRL_IDX, 8'hC0);
    n = 0;
    for (k = 0; k < 8; k++) begin
      #1;
      n += (core_reset === 1'b1);
      @(posedge core_clk);
    end
    `CHK("soft reset cycles", 4, n)
    `CHK("break off", 1'b0, tx_line_break)
    rd(serial_ctrl_pkg::DIV_LOW_IDX, 8'h00);
    rd(serial_ctrl_pkg::RESET_CTRL_IDX, 8'h80);
    // Pin reset in the middle of a soft reset stops it at once
    bus(1'b1, serial_ctrl_pkg::RESET_CTRL_IDX, 8'hC0);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK("soft reset cut", 1'b0, core_reset)
    rd(serial_ctrl_pkg::MODE_CTRL_IDX, 8'h01);
    settle();
    test_done();
  end
endmodule
